/* File: hw/fcr_defs.svh */
// register map, field positions, reset values and timing counts of the flash register bank
`ifndef FCR_DEFS_SVH
`define FCR_DEFS_SVH

// ============================================================
// address map
`define FCR_BASE_ADDR        32'hFFFFFF00
`define FCR_BASE_MASK        32'hFFFFFF00
`define FCR_MODE0_OFS        8'h60
`define FCR_CMD0_OFS         8'h64
`define FCR_STAT0_OFS        8'h68
`define FCR_RSVD0_OFS        8'h6C
`define FCR_MODE1_OFS        8'h70
`define FCR_CMD1_OFS         8'h74
`define FCR_STAT1_OFS        8'h78
`define FCR_RSVD1_OFS        8'h7C
`define FCR_EVT_STAT_OFS     8'h80
`define FCR_EVT_MASK_OFS     8'h84

// ============================================================
// mode register fields
`define FCR_MODE_RESET       32'h00000000
`define FCR_MODE_WMASK       32'h00FF0B0D
`define FCR_MODE_RDY_BIT     0
`define FCR_MODE_LOCK_ERROR_IRQ_ENABLE_BIT   2
`define FCR_MODE_PROGRAM_ERROR_IRQ_ENABLE_BIT   3

// ============================================================
// command register fields
`define FCR_KEY_MSB          31
`define FCR_KEY_LSB          24
`define FCR_KEY_VALUE        8'h5A
`define FCR_PAGE_MSB         17
`define FCR_PAGE_LSB         8
`define FCR_REGION_MSB       17
`define FCR_REGION_LSB       14
`define FCR_CMD_MSB          3
`define FCR_CMD_LSB          0

// ============================================================
// status register fields
`define FCR_STAT_RDY_BIT     0
`define FCR_STAT_LOCK_ERROR_IRQ_ENABLE_BIT   2
`define FCR_STAT_PROGRAM_ERROR_IRQ_ENABLE_BIT   3
`define FCR_STAT_SEC_BIT     4
`define FCR_STAT_GP_LSB      8
`define FCR_STAT_LOCKS_LSB   16
`define FCR_GP_COUNT         3

// ============================================================
// event register and timing
`define FCR_EVT_RESET        6'h00
`define FCR_OP_TIME_NS       640
`define FCR_CLK_PERIOD_NS    40
`define FCR_OP_CYCLES        ((`FCR_OP_TIME_NS + `FCR_CLK_PERIOD_NS - 1) / `FCR_CLK_PERIOD_NS)

`endif

/* File: hw/fcr_pkg.sv */
// types shared by the flash register bank modules
package fcr_pkg;

    // ============================================================
    // flash commands
    typedef enum logic [3:0] {
        FCR_CMD_NONE = 4'b0000,
        FCR_CMD_WP   = 4'b0001,
        FCR_CMD_SLB  = 4'b0010,
        FCR_CMD_WPL  = 4'b0011,
        FCR_CMD_CLB  = 4'b0100,
        FCR_CMD_EA   = 4'b1000,
        FCR_CMD_SGPB = 4'b1011,
        FCR_CMD_CGPB = 4'b1101,
        FCR_CMD_SSB  = 4'b1111
    } fcr_cmd_type;

    // ============================================================
    // controller states
    typedef enum logic [1:0] {
        FCR_ST_IDLE = 2'b00,
        FCR_ST_BUSY = 2'b01,
        FCR_ST_DONE = 2'b10
    } fcr_state_type;

    // ============================================================
    // bus write states
    typedef enum logic [1:0] {
        FCR_WR_IDLE = 2'b00,
        FCR_WR_RESP = 2'b01
    } fcr_wr_state_type;

endpackage : fcr_pkg

/* File: hw/fcr_bank_if.sv */
// link between the register decoder and one flash controller instance
`timescale 1ns/1ps
interface fcr_bank_if;
    logic        mode_wr;
    logic        cmd_wr;
    logic        stat_rd;
    logic [31:0] wdata;
    logic [31:0] mode;
    logic [31:0] status;
    logic        irq;
    logic        ready_evt;
    logic        lock_err_evt;
    logic        prog_err_evt;

    modport ctrl (output mode_wr, cmd_wr, stat_rd, wdata,
                  input  mode, status, irq, ready_evt, lock_err_evt, prog_err_evt);
    modport bank (input  mode_wr, cmd_wr, stat_rd, wdata,
                  output mode, status, irq, ready_evt, lock_err_evt, prog_err_evt);
endinterface : fcr_bank_if

/* File: hw/fcr_bank.sv */
// one flash controller instance: mode, command and status registers
`timescale 1ns/1ps
`include "fcr_defs.svh"
module fcr_bank
    import fcr_pkg::*;
(
    // clock and reset
    input  wire logic   sys_clk,
    input  wire logic   reset,
    input  wire logic   clk_en,
    // decoder side
    fcr_bank_if.bank    bus
);
    localparam int OP_CYCLES = `FCR_OP_CYCLES;

    fcr_state_type state_reg;
    logic [31:0]   mode_reg;
    logic          ready_reg;
    logic          lock_error_irq_enable_reg;
    logic          program_error_irq_enable_reg;
    logic          sec_reg;
    logic [2:0]    gp_reg;
    logic [15:0]   locks_reg;
    logic [7:0]    count_reg;
    fcr_cmd_type   op_reg;
    logic [9:0]    page_reg;
    logic          irq_reg;

    logic          key_ok;
    logic [3:0]    cmd_code;
    logic          cmd_known;
    logic          lock_hit;
    logic          set_lock_error_irq_enable;
    logic          set_program_error_irq_enable;
    logic          start_op;

    assign key_ok   = bus.wdata[`FCR_KEY_MSB:`FCR_KEY_LSB] == `FCR_KEY_VALUE;
    assign cmd_code = bus.wdata[`FCR_CMD_MSB:`FCR_CMD_LSB];

    // ============================================================
    // command decode
    always_comb begin
        cmd_known = 1'b1;
        lock_hit  = 1'b0;
        case (cmd_code)
            FCR_CMD_WP, FCR_CMD_WPL:
                lock_hit = locks_reg[bus.wdata[`FCR_REGION_MSB:`FCR_REGION_LSB]];
            FCR_CMD_EA:
                lock_hit = |locks_reg;
            FCR_CMD_NONE, FCR_CMD_SLB, FCR_CMD_CLB, FCR_CMD_SGPB, FCR_CMD_CGPB,
            FCR_CMD_SSB:
                lock_hit = 1'b0;
            default:
                cmd_known = 1'b0;
        endcase
    end

    // wrong key: nothing at all happens, not even an error flag
    assign set_program_error_irq_enable = bus.cmd_wr && key_ok && !cmd_known;
    assign set_lock_error_irq_enable = bus.cmd_wr && key_ok && cmd_known && lock_hit && ready_reg;
    assign start_op  = bus.cmd_wr && key_ok && cmd_known && !lock_hit && ready_reg
                       && (cmd_code != FCR_CMD_NONE);

    // ============================================================
    // mode register
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            mode_reg <= `FCR_MODE_RESET;
        end else if (clk_en && bus.mode_wr) begin
            mode_reg <= bus.wdata & `FCR_MODE_WMASK;
        end
    end

    // ============================================================
    // operation sequencer
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            state_reg <= FCR_ST_IDLE;
            count_reg <= 8'h00;
            op_reg    <= FCR_CMD_NONE;
            page_reg  <= 10'h000;
        end else if (clk_en) begin
            case (state_reg)
                FCR_ST_IDLE: begin
                    if (start_op) begin
                        state_reg <= FCR_ST_BUSY;
                        count_reg <= 8'(OP_CYCLES - 1);
                        op_reg    <= fcr_cmd_type'(cmd_code);
                        page_reg  <= bus.wdata[`FCR_PAGE_MSB:`FCR_PAGE_LSB];
                    end
                end
                FCR_ST_BUSY: begin
                    if (count_reg == 8'h00) begin
                        state_reg <= FCR_ST_DONE;
                    end else begin
                        count_reg <= count_reg - 8'h01;
                    end
                end
                FCR_ST_DONE: begin
                    state_reg <= FCR_ST_IDLE;
                end
                default: begin
                    state_reg <= FCR_ST_IDLE;
                end
            endcase
        end
    end

    // ============================================================
    // ready flag: low while a command runs
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            ready_reg <= 1'b1;
        end else if (clk_en) begin
            if (start_op) begin
                ready_reg <= 1'b0;
            end else if (state_reg == FCR_ST_DONE) begin
                ready_reg <= 1'b1;
            end
        end
    end

    // ============================================================
    // error flags clear on status read, a new error in that cycle wins
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            lock_error_irq_enable_reg <= 1'b0;
            program_error_irq_enable_reg <= 1'b0;
        end else if (clk_en) begin
            lock_error_irq_enable_reg <= set_lock_error_irq_enable | (lock_error_irq_enable_reg & ~bus.stat_rd);
            program_error_irq_enable_reg <= set_program_error_irq_enable | (program_error_irq_enable_reg & ~bus.stat_rd);
        end
    end

    // ============================================================
    // nonvolatile state changed at the end of an operation
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            locks_reg <= 16'h0000;
            gp_reg    <= 3'h0;
            sec_reg   <= 1'b0;
        end else if (clk_en && state_reg == FCR_ST_DONE) begin
            case (op_reg)
                FCR_CMD_SLB, FCR_CMD_WPL:
                    locks_reg[page_reg[9:6]] <= 1'b1;
                FCR_CMD_CLB:
                    locks_reg[page_reg[9:6]] <= 1'b0;
                FCR_CMD_SGPB:
                    if (page_reg < 10'(`FCR_GP_COUNT)) gp_reg[page_reg[1:0]] <= 1'b1;
                FCR_CMD_CGPB:
                    if (page_reg < 10'(`FCR_GP_COUNT)) gp_reg[page_reg[1:0]] <= 1'b0;
                FCR_CMD_SSB:
                    sec_reg <= 1'b1;
                default: begin
                end
            endcase
        end
    end

    // ============================================================
    // interrupt: each flag gated by its enable in the mode register
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            irq_reg <= 1'b0;
        end else if (clk_en) begin
            irq_reg <= (ready_reg & mode_reg[`FCR_MODE_RDY_BIT])
                     | (lock_error_irq_enable_reg & mode_reg[`FCR_MODE_LOCK_ERROR_IRQ_ENABLE_BIT])
                     | (program_error_irq_enable_reg & mode_reg[`FCR_MODE_PROGRAM_ERROR_IRQ_ENABLE_BIT]);
        end
    end

    always_comb begin
        bus.status = 32'h00000000;
        bus.status[`FCR_STAT_RDY_BIT]   = ready_reg;
        bus.status[`FCR_STAT_LOCK_ERROR_IRQ_ENABLE_BIT] = lock_error_irq_enable_reg;
        bus.status[`FCR_STAT_PROGRAM_ERROR_IRQ_ENABLE_BIT] = program_error_irq_enable_reg;
        bus.status[`FCR_STAT_SEC_BIT]   = sec_reg;
        bus.status[`FCR_STAT_GP_LSB +: `FCR_GP_COUNT] = gp_reg;
        bus.status[`FCR_STAT_LOCKS_LSB +: 16]         = locks_reg;
    end

    assign bus.mode         = mode_reg;
    assign bus.irq          = irq_reg;
    assign bus.ready_evt    = clk_en && state_reg == FCR_ST_DONE;
    assign bus.lock_err_evt = clk_en && set_lock_error_irq_enable;
    assign bus.prog_err_evt = clk_en && set_program_error_irq_enable;

endmodule : fcr_bank

/* File: hw/fcr_regs.sv */
// AXI4-Lite register interface of two flash controller instances
// ============================================================
//
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "fcr_defs.svh"
module fcr_regs
    import fcr_pkg::*;
(
    // clock, reset, enable
    input  wire logic        sys_clk,
    input  wire logic        reset,
    input  wire logic        clk_en,
    // write address channel
    input  wire logic [31:0] s_axi_awaddr,
    input  wire logic [2:0]  s_axi_awprot,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    // write data channel
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // write response channel
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // read address channel
    input  wire logic [31:0] s_axi_araddr,
    input  wire logic [2:0]  s_axi_arprot,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    // read data channel
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // interrupt
    output logic             mc_irq
);
    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    localparam int         BANKS       = 2;

    // ============================================================
    // address decode
    typedef enum logic [2:0] {
        FCR_SEL_MODE = 3'b000,
        FCR_SEL_CMD  = 3'b001,
        FCR_SEL_STAT = 3'b010,
        FCR_SEL_RSVD = 3'b011,
        FCR_SEL_EVTS = 3'b100,
        FCR_SEL_EVTM = 3'b101,
        FCR_SEL_NONE = 3'b110
    } fcr_sel_type;

    // which register of the window, and which bank for bank registers
    function automatic fcr_sel_type decode_sel(input logic [31:0] addr);
        if ((addr & `FCR_BASE_MASK) != `FCR_BASE_ADDR) begin
            return FCR_SEL_NONE;
        end
        case (addr[7:0])
            `FCR_MODE0_OFS, `FCR_MODE1_OFS: return FCR_SEL_MODE;
            `FCR_CMD0_OFS,  `FCR_CMD1_OFS:  return FCR_SEL_CMD;
            `FCR_STAT0_OFS, `FCR_STAT1_OFS: return FCR_SEL_STAT;
            `FCR_RSVD0_OFS, `FCR_RSVD1_OFS: return FCR_SEL_RSVD;
            `FCR_EVT_STAT_OFS:              return FCR_SEL_EVTS;
            `FCR_EVT_MASK_OFS:              return FCR_SEL_EVTM;
            default:                        return FCR_SEL_NONE;
        endcase
    endfunction : decode_sel

    function automatic logic decode_bank(input logic [31:0] addr);
        return addr[4];
    endfunction : decode_bank

    // ============================================================
    // bank instances
    fcr_bank_if bank_if [BANKS] ();

    logic [31:0]      wr_addr_reg;
    logic [31:0]      wr_data_reg;
    logic [3:0]       wr_strb_reg;
    logic             aw_held_reg;
    logic             w_held_reg;
    logic             do_write;
    fcr_sel_type      wr_sel;
    logic             wr_bank;
    fcr_sel_type      rd_sel;
    logic             rd_bank;
    logic             do_read;
    logic [31:0]      mode_rd   [BANKS];
    logic [31:0]      status_rd [BANKS];
    logic [BANKS-1:0] bank_irq;
    logic [5:0]       evt_pulse;
    logic [5:0]       evt_stat_reg;
    logic [5:0]       evt_mask_reg;

    assign wr_sel   = decode_sel(wr_addr_reg);
    assign wr_bank  = decode_bank(wr_addr_reg);
    assign rd_sel   = decode_sel(s_axi_araddr);
    assign rd_bank  = decode_bank(s_axi_araddr);
    assign do_write = clk_en && aw_held_reg && w_held_reg && !s_axi_bvalid;
    assign do_read  = clk_en && s_axi_arvalid && s_axi_arready;

    genvar gi;
    generate
        for (gi = 0; gi < BANKS; gi++) begin : g_bank
            // command and mode writes need all four lanes; partial writes are dropped
            assign bank_if[gi].mode_wr = do_write && wr_sel == FCR_SEL_MODE
                                         && wr_bank == 1'(gi) && &wr_strb_reg;
            assign bank_if[gi].cmd_wr  = do_write && wr_sel == FCR_SEL_CMD
                                         && wr_bank == 1'(gi) && &wr_strb_reg;
            assign bank_if[gi].stat_rd = do_read && rd_sel == FCR_SEL_STAT
                                         && rd_bank == 1'(gi);
            assign bank_if[gi].wdata   = wr_data_reg;
            assign mode_rd[gi]         = bank_if[gi].mode;
            assign status_rd[gi]       = bank_if[gi].status;
            assign bank_irq[gi]        = bank_if[gi].irq;
            assign evt_pulse[gi*3]     = bank_if[gi].ready_evt;
            assign evt_pulse[gi*3+1]   = bank_if[gi].lock_err_evt;
            assign evt_pulse[gi*3+2]   = bank_if[gi].prog_err_evt;

            fcr_bank u_bank (
                .sys_clk (sys_clk),
                .reset   (reset),
                .clk_en  (clk_en),
                .bus     (bank_if[gi])
            );
        end
    endgenerate

    // ============================================================
    // write address and data capture, either order
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            aw_held_reg   <= 1'b0;
            s_axi_awready <= 1'b0;
            wr_addr_reg   <= 32'h00000000;
        end else if (clk_en) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_reg   <= 1'b1;
                s_axi_awready <= 1'b0;
                wr_addr_reg   <= s_axi_awaddr;
            end else if (do_write) begin
                aw_held_reg   <= 1'b0;
            end else begin
                s_axi_awready <= !aw_held_reg && !s_axi_bvalid;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            w_held_reg   <= 1'b0;
            s_axi_wready <= 1'b0;
            wr_data_reg  <= 32'h00000000;
            wr_strb_reg  <= 4'h0;
        end else if (clk_en) begin
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_reg   <= 1'b1;
                s_axi_wready <= 1'b0;
                wr_data_reg  <= s_axi_wdata;
                wr_strb_reg  <= s_axi_wstrb;
            end else if (do_write) begin
                w_held_reg   <= 1'b0;
            end else begin
                s_axi_wready <= !w_held_reg && !s_axi_bvalid;
            end
        end
    end

    // ============================================================
    // write response
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else if (clk_en) begin
            if (do_write) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (wr_sel == FCR_SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ============================================================
    // read channel
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= RESP_OKAY;
        end else if (clk_en) begin
            if (do_read) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rresp   <= RESP_OKAY;
                case (rd_sel)
                    FCR_SEL_MODE: s_axi_rdata <= mode_rd[rd_bank];
                    FCR_SEL_STAT: s_axi_rdata <= status_rd[rd_bank];
                    FCR_SEL_EVTS: s_axi_rdata <= {26'h0000000, evt_stat_reg};
                    FCR_SEL_EVTM: s_axi_rdata <= {26'h0000000, evt_mask_reg};
                    // command register is write-only, reserved words read zero
                    FCR_SEL_CMD, FCR_SEL_RSVD: s_axi_rdata <= 32'h00000000;
                    default: begin
                        s_axi_rdata <= 32'h00000000;
                        s_axi_rresp <= RESP_SLVERR;
                    end
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid  <= 1'b0;
            end else begin
                s_axi_arready <= !s_axi_rvalid;
            end
        end
    end

    // ============================================================
    // event status, write one to clear; a new event wins over the clear
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            evt_stat_reg <= `FCR_EVT_RESET;
        end else if (clk_en) begin
            if (do_write && wr_sel == FCR_SEL_EVTS && wr_strb_reg[0]) begin
                evt_stat_reg <= (evt_stat_reg & ~wr_data_reg[5:0]) | evt_pulse;
            end else begin
                evt_stat_reg <= evt_stat_reg | evt_pulse;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            evt_mask_reg <= `FCR_EVT_RESET;
        end else if (clk_en && do_write && wr_sel == FCR_SEL_EVTM && wr_strb_reg[0]) begin
            evt_mask_reg <= wr_data_reg[5:0];
        end
    end

    // ============================================================
    // interrupt line of the memory controller
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            mc_irq <= 1'b0;
        end else if (clk_en) begin
            mc_irq <= (|bank_irq) | (|(evt_stat_reg & evt_mask_reg));
        end
    end

endmodule : fcr_regs

/* File: tb/fcr_regs_chk.sv */
// port-level assertions for the flash register bank
`timescale 1ns/1ps
module fcr_regs_chk (
    // clock, reset, enable
    input wire logic        sys_clk, reset, clk_en,
    // bus payloads
    input wire logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata,
    input wire logic [2:0]  s_axi_awprot, s_axi_arprot,
    input wire logic [3:0]  s_axi_wstrb,
    input wire logic [1:0]  s_axi_bresp, s_axi_rresp,
    // handshakes and interrupt
    input wire logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready,
    input wire logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready,
    input wire logic        s_axi_rvalid, s_axi_rready, mc_irq
);
    // ============================================================
    // handshake sequences
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    sequence s_wr_taken;
        clk_en && s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_rd_taken;
        clk_en && s_axi_arvalid && s_axi_arready;
    endsequence
    // ============================================================
    // assertions
    a_write_answer: assert property (s_wr_taken |-> ##[1:3] s_axi_bvalid)
        else $error("write not answered in time");
    a_read_answer: assert property (s_rd_taken |=> s_axi_rvalid)
        else $error("read not answered next cycle");
    a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    a_aw_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted while response pending");
    a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read accepted while data pending");
    a_slverr_zero: assert property (s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0)
        else $error("error read returned data");
    a_irq_reset: assert property (@(posedge sys_clk) disable iff (1'h0)
        reset && clk_en |=> !mc_irq && !s_axi_bvalid && !s_axi_rvalid)
        else $error("outputs active after reset");
endmodule : fcr_regs_chk

bind fcr_regs fcr_regs_chk fcr_regs_chk_inst (.*);

/* File: tb/tb_top.sv */
// self-checking bench for the flash register bank
`timescale 1ns/1ps
module tb_top;
    // ============================================================
    // signals
    logic        sys_clk = 1'h0, reset = 1'h1, clk_en = 1'h1;
    logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, s_axi_rdata;
    logic [2:0]  s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, mc_irq;
    int          fails = 0, n_checks = 0;
    localparam logic [31:0] B = 32'hFFFFFF00;
    localparam logic [1:0]  OK = 2'h0, ERR = 2'h2;
    fcr_regs fcr_regs_inst (.*);
    always #20 sys_clk = ~sys_clk;
    // ============================================================
    // tasks
    task automatic chk(input logic [31:0] got, exp);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic test_done();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : test_done
    task automatic wr(input logic [31:0] a, d, input logic [1:0] r);
        @(posedge sys_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        // response is taken at the edge where bvalid is sampled high
        do begin
            @(posedge sys_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'h0;
        chk({30'h0, s_axi_bresp}, {30'h0, r});
    endtask : wr
    task automatic rd(input logic [31:0] a, d, input logic [1:0] r);
        @(posedge sys_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do begin
            @(posedge sys_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'h0;
        chk(s_axi_rdata, d);
        chk({30'h0, s_axi_rresp}, {30'h0, r});
    endtask : rd
    // interrupt is registered, so give it a few cycles to settle
    task automatic irq(input logic e);
        repeat (3) @(posedge sys_clk);
        chk({31'h0, mc_irq}, {31'h0, e});
    endtask : irq
    // ============================================================
    // tests
    initial begin
        repeat (3000) @(posedge sys_clk);
        fails++;
        test_done();
    end
    initial begin
        repeat (16) @(posedge sys_clk);
        reset <= 1'h0;
        rd(B + 8'h60, 32'h0, OK);
        rd(B + 8'h70, 32'h0, OK);
        rd(B + 8'h68, 32'h1, OK);
        rd(B + 8'h78, 32'h1, OK);
        rd(B + 8'h6C, 32'h0, OK);
        rd(B + 8'h64, 32'h0, OK);
        wr(B + 8'h60, 32'hFFFFFFFF, OK);
        rd(B + 8'h60, 32'h00FF0B0D, OK);
        rd(B + 8'h70, 32'h0, OK);
        s_axi_wstrb <= 4'h1;
        wr(B + 8'h70, 32'hFFFFFFFF, OK);
        s_axi_wstrb <= 4'hF;
        rd(B + 8'h70, 32'h0, OK);
        irq(1'h1);
        wr(B + 8'h60, 32'h8, OK);
        irq(1'h0);
        wr(B + 8'h64, 32'hA5000001, OK);
        rd(B + 8'h68, 32'h1, OK);
        wr(B + 8'h64, 32'h5A00000E, OK);
        irq(1'h1);
        rd(B + 8'h68, 32'h9, OK);
        rd(B + 8'h68, 32'h1, OK);
        irq(1'h0);
        wr(B + 8'h60, 32'h1, OK);
        wr(B + 8'h64, 32'h5A000001, OK);
        rd(B + 8'h68, 32'h0, OK);
        irq(1'h0);
        repeat (20) @(posedge sys_clk);
        irq(1'h1);
        rd(B + 8'h68, 32'h1, OK);
        wr(B + 8'h60, 32'h0, OK);
        wr(B + 8'h70, 32'h4, OK);
        wr(B + 8'h74, 32'h5A000002, OK);
        repeat (20) @(posedge sys_clk);
        rd(B + 8'h78, 32'h00010001, OK);
        wr(B + 8'h74, 32'h5A000001, OK);
        irq(1'h1);
        rd(B + 8'h78, 32'h00010005, OK);
        irq(1'h0);
        rd(B + 8'h68, 32'h1, OK);
        wr(B + 8'h74, 32'h5A000008, OK);
        rd(B + 8'h78, 32'h00010005, OK);
        wr(B + 8'h74, 32'h5A000004, OK);
        repeat (20) @(posedge sys_clk);
        wr(B + 8'h74, 32'h5A00010B, OK);
        repeat (20) @(posedge sys_clk);
        wr(B + 8'h74, 32'h5A00000F, OK);
        repeat (20) @(posedge sys_clk);
        rd(B + 8'h78, 32'h00000211, OK);
        wr(B + 8'h80, 32'h3F, OK);
        wr(B + 8'h84, 32'h1, OK);
        wr(B + 8'h64, 32'h5A000001, OK);
        // a frozen enable must also freeze the running operation
        clk_en <= 1'h0;
        repeat (30) @(posedge sys_clk);
        clk_en <= 1'h1;
        rd(B + 8'h68, 32'h0, OK);
        repeat (20) @(posedge sys_clk);
        irq(1'h1);
        wr(B + 8'h84, 32'h0, OK);
        irq(1'h0);
        rd(B + 8'h80, 32'h1, OK);
        wr(B + 8'h80, 32'h1, OK);
        rd(B + 8'h80, 32'h0, OK);
        rd(B + 8'h90, 32'h0, ERR);
        rd(32'h00000060, 32'h0, ERR);
        wr(B + 8'h88, 32'h1, ERR);
        test_done();
    end
endmodule : tb_top
